// [src/sideband_pkg.sv]
// Contract
// - Master aborts if no DEVSEL within 5 clocks
// - Target drives DEVSEL two clocks after address
// - REQ released and GNT ignored during reset
// - Master data parity error sets flags, stops
// - Target data parity error only drives PERR
// - SERR pulses one clock within two clocks
// - SERR enabled address error sets bits 31,30
// - Address parity error sets interrupt bit 13
// - INTA held while any unmasked status set
// - PME bits reset only by sticky reset
// - Power good low isolates all bus pins but PME
// - PME asserted on power management event
// - CLKRUN requests clock, read as clock status
// - Wake output has four selectable forms
// - Card status change follows PME, active high
// - Bus reset floats outputs, restores configuration; CLKRUN and PME are not floated
// - Even parity over AD and CBE, delayed
package sideband_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CMD  = 8'h04;
	localparam logic [7:0] OFS_ISR  = 8'h14;
	localparam logic [7:0] OFS_IMR  = 8'h18;
	localparam logic [7:0] OFS_PM   = 8'h1c;
	localparam logic [7:0] OFS_SIDE = 8'h20;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CMD_MST_EN   = 2;
	localparam int CMD_PAR_RESP = 6;
	localparam int CMD_SERR_EN  = 8;
	localparam int ST_MST_PERR  = 24;
	localparam int ST_MST_ABORT = 29;
	localparam int ST_SIG_SERR  = 30;
	localparam int ST_DET_PERR  = 31;
	localparam int ISR_BUS_ERR  = 13;
	localparam int PM_PME_EN    = 8;
	localparam int PM_PME_ST    = 15;
	localparam int PM_FORM_LO   = 16;
	localparam int PM_CARDBUS   = 18;
	localparam int PM_WAKE_ST   = 19;

	localparam logic [31:0] CMD_RW_MASK  = 32'h0000_0144;
	localparam logic [31:0] CMD_W1C_MASK = 32'he100_0000;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [31:0] CMD_RST = 32'h0000_0000;
	localparam logic [15:0] ISR_RST = 16'h0000;
	localparam logic [15:0] IMR_RST = 16'h0000;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          CLK_PERIOD_NS    = 5;
	localparam logic [2:0]  MST_DEVSEL_CLKS  = 3'h5;
	localparam logic [3:0]  BUS_RST_MIN_CLKS = 4'ha;
	localparam logic [1:0]  CLKRUN_HOLD_CLKS = 2'h2;
	localparam int          WAKE_CNT_W       = 4;
	localparam int          WAKE_PULSE_NS    = 40;
	localparam logic [WAKE_CNT_W-1:0] WAKE_PULSE_CYC =
		WAKE_CNT_W'((WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {
		WAKE_HIGH = 2'b00,
		WAKE_LOW  = 2'b01,
		WAKE_POS  = 2'b10,
		WAKE_NEG  = 2'b11
	} wake_form_e;

	typedef enum logic [1:0] {
		DS_IDLE = 2'b00,
		DS_WAIT = 2'b01,
		DS_ACT  = 2'b10,
		DS_PARK = 2'b11
	} dsel_e;

	typedef enum logic [1:0] {
		PE_IDLE = 2'b00,
		PE_LOW  = 2'b01,
		PE_HIGH = 2'b10
	} perr_e;

endpackage

// [src/od_pin.sv]
`timescale 1ns/1ps
`default_nettype none
module od_pin (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic en,
	input  wire logic assert_in,
	output logic      pin_n_out,
	output logic      pin_oe
);
	typedef struct packed {
		logic drive;
	} od_s;

	od_s od_r;
	od_s od_nxt;

	always_comb begin
		od_nxt       = od_r;
		od_nxt.drive = assert_in & en;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			od_r <= '0;
		end else begin
			od_r <= od_nxt;
		end
	end

	// Level is fixed low; only the enable moves
	assign pin_n_out = 1'b0;
	assign pin_oe    = od_r.drive & en;
endmodule
`default_nettype wire

// [src/par_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module par_unit (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        en,
	input  wire logic [31:0] ad_in,
	input  wire logic [3:0]  cbe_in,
	input  wire logic        par_in,
	input  wire logic        chk_valid,
	input  wire logic        chk_addr,
	input  wire logic        drive,
	output logic             addr_err,
	output logic             data_err,
	output logic             par_out,
	output logic             par_oe
);
	typedef struct packed {
		logic par;
		logic chk;
		logic is_addr;
		logic oe;
	} pu_s;

	pu_s pu_r;
	pu_s pu_nxt;

	always_comb begin
		pu_nxt         = pu_r;
		pu_nxt.par     = ^{ad_in, cbe_in};
		pu_nxt.chk     = chk_valid;
		pu_nxt.is_addr = chk_addr;
		pu_nxt.oe      = drive;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pu_r <= '0;
		end else begin
			pu_r <= pu_nxt;
		end
	end

	// Parity trails its data by one clock
	assign addr_err = en & pu_r.chk & pu_r.is_addr & (par_in != pu_r.par);
	assign data_err = en & pu_r.chk & ~pu_r.is_addr & (par_in != pu_r.par);
	assign par_out  = pu_r.par;
	assign par_oe   = pu_r.oe & en;
endmodule
`default_nettype wire

// [src/pci_sideband.sv]
`timescale 1ns/1ps
`default_nettype none
module pci_sideband import sideband_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        aux_sticky_reset_n,
	input  wire logic        bus_reset_n,
	input  wire logic        bus_power_good_in,
	input  wire logic        idsel_in,
	input  wire logic        addr_phase_in,
	input  wire logic        data_phase_in,
	input  wire logic [31:0] ad_in,
	input  wire logic [3:0]  cbe_in,
	input  wire logic        par_in,
	input  wire logic        par_drive_in,
	output logic             par_out,
	output logic             par_oe,
	input  wire logic        is_master_in,
	input  wire logic        mst_req_in,
	input  wire logic        gnt_n_in,
	output logic             req_n_out,
	output logic             req_oe,
	output logic             mst_grant_out,
	input  wire logic        mst_cmd_in,
	input  wire logic        devsel_n_in,
	output logic             mst_abort_out,
	output logic             mst_stop_out,
	input  wire logic        tgt_hit_in,
	input  wire logic        tgt_done_in,
	output logic             cfg_access_out,
	output logic             devsel_n_out,
	output logic             devsel_oe,
	output logic             perr_n_out,
	output logic             perr_oe,
	output logic             serr_n_out,
	output logic             serr_oe,
	output logic             inta_n_out,
	output logic             inta_oe,
	output logic             pme_n_out,
	output logic             pme_oe,
	input  wire logic        clkrun_n_in,
	input  wire logic        clk_need_in,
	output logic             clkrun_n_out,
	output logic             clkrun_oe,
	input  wire logic [15:0] irq_evt_in,
	input  wire logic        wake_pkt_in,
	input  wire logic        link_chg_in,
	input  wire logic        wake_frame_in,
	output logic             wake_event_out,
	output logic             cstschg_out
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] cmd;
		logic [15:0] isr;
		logic [15:0] imr;
		logic        req;
		logic        mst_wait;
		logic [2:0]  mst_cnt;
		logic        mst_abort;
		logic        mst_stop;
		dsel_e       ds;
		logic        cfg;
		perr_e       pe;
		logic        serr;
		logic [1:0]  ckr_cnt;
		logic [3:0]  rst_cnt;
		logic        rst_ok;
		logic [31:0] rdata;
		logic        slverr;
	} core_s;

	typedef struct packed {
		logic                  pme_en;
		logic                  pme_st;
		wake_form_e            form;
		logic                  cardbus;
		logic                  wake_st;
		logic [WAKE_CNT_W-1:0] pcnt;
		logic                  wake_out;
		logic                  cst;
	} pm_s;

	localparam core_s CORE_RST = '{cmd: CMD_RST, isr: ISR_RST, imr: IMR_RST,
		ds: DS_IDLE, pe: PE_IDLE, default: '0};
	localparam pm_s PM_RST = '{form: WAKE_HIGH, default: '0};

	core_s c_r;
	core_s c_nxt;
	pm_s   pm_r;
	pm_s   pm_nxt;

	logic        live;
	logic        setup;
	logic        wr;
	logic        t_hit;
	logic        dsel_seen;
	logic        wake_ev;
	logic        addr_err;
	logic        data_err;
	logic [31:0] rd;
	logic        mapped;

	// ----------------------------------------
	// Qualifiers
	// ----------------------------------------
	// Bus inputs count only with power good and no bus reset; CLKRUN needs only power good
	assign live      = bus_reset_n & bus_power_good_in;
	assign setup     = psel & ~penable;
	assign wr        = psel & penable & pwrite;
	assign t_hit     = live & addr_phase_in & (tgt_hit_in | idsel_in);
	assign dsel_seen = live & ~devsel_n_in;
	assign wake_ev   = wake_pkt_in | link_chg_in | wake_frame_in;

	par_unit u_par (
		.clk       (pclk),
		.rst_n     (presetn),
		.en        (live),
		.ad_in     (ad_in),
		.cbe_in    (cbe_in),
		.par_in    (par_in),
		.chk_valid ((addr_phase_in | data_phase_in) & live),
		.chk_addr  (addr_phase_in),
		.drive     (par_drive_in & live),
		.addr_err  (addr_err),
		.data_err  (data_err),
		.par_out   (par_out),
		.par_oe    (par_oe)
	);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb begin
		rd     = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			OFS_CMD: begin
				rd = c_r.cmd;
			end
			OFS_ISR: begin
				rd = {16'h0000, c_r.isr};
			end
			OFS_IMR: begin
				rd = {16'h0000, c_r.imr};
			end
			OFS_PM: begin
				rd = {12'h000, pm_r.wake_st, pm_r.cardbus, pm_r.form, pm_r.pme_st,
					6'h00, pm_r.pme_en, 8'h00};
			end
			OFS_SIDE: begin
				rd = {26'h0000000, ~clkrun_n_in, c_r.req, c_r.mst_wait,
					c_r.ds == DS_ACT, c_r.rst_ok, bus_power_good_in};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Core next state
	// ----------------------------------------
	always_comb begin
		c_nxt           = c_r;
		c_nxt.mst_abort = 1'b0;
		c_nxt.mst_stop  = 1'b0;
		c_nxt.serr      = 1'b0;
		c_nxt.cfg       = live & addr_phase_in & idsel_in;
		if (setup) begin
			c_nxt.rdata  = rd;
			c_nxt.slverr = ~mapped;
		end
		// Software clears first so hardware sets below win
		if (wr) begin
			case (paddr)
				OFS_CMD: begin
					c_nxt.cmd = (c_r.cmd & ~CMD_RW_MASK & ~(pwdata & CMD_W1C_MASK))
						| (pwdata & CMD_RW_MASK);
				end
				OFS_ISR: begin
					c_nxt.isr = c_r.isr & ~pwdata[15:0];
				end
				OFS_IMR: begin
					c_nxt.imr = pwdata[15:0];
				end
				default: begin
				end
			endcase
		end
		c_nxt.isr = c_nxt.isr | irq_evt_in;
		c_nxt.req = mst_req_in & c_nxt.cmd[CMD_MST_EN] & live;
		// Master DEVSEL watchdog
		if (live && mst_cmd_in) begin
			c_nxt.mst_wait = 1'b1;
			c_nxt.mst_cnt  = 3'h0;
		end else if (c_r.mst_wait) begin
			if (dsel_seen) begin
				c_nxt.mst_wait = 1'b0;
			end else if (c_r.mst_cnt == MST_DEVSEL_CLKS - 3'h1) begin
				c_nxt.mst_wait            = 1'b0;
				c_nxt.mst_abort           = 1'b1;
				c_nxt.cmd[ST_MST_ABORT]   = 1'b1;
				c_nxt.cmd[CMD_MST_EN]     = 1'b0;
				c_nxt.req                 = 1'b0;
			end else begin
				c_nxt.mst_cnt = c_r.mst_cnt + 3'h1;
			end
		end
		// Data parity
		if (data_err && is_master_in && c_r.cmd[CMD_PAR_RESP]) begin
			c_nxt.cmd[ST_MST_PERR] = 1'b1;
			c_nxt.isr[ISR_BUS_ERR] = 1'b1;
			c_nxt.mst_stop         = 1'b1;
		end
		case (c_r.pe)
			PE_IDLE: begin
				if (data_err && !is_master_in && c_r.cmd[CMD_PAR_RESP]) begin
					c_nxt.pe = PE_LOW;
				end
			end
			PE_LOW: begin
				c_nxt.pe = PE_HIGH;
			end
			PE_HIGH: begin
				c_nxt.pe = PE_IDLE;
			end
			default: begin
				c_nxt.pe = PE_IDLE;
			end
		endcase
		// Address parity
		if (addr_err && c_r.cmd[CMD_SERR_EN]) begin
			c_nxt.serr             = 1'b1;
			c_nxt.cmd[ST_DET_PERR] = 1'b1;
			c_nxt.cmd[ST_SIG_SERR] = 1'b1;
		end
		if (addr_err && c_r.cmd[CMD_PAR_RESP]) begin
			c_nxt.isr[ISR_BUS_ERR] = 1'b1;
		end
		// Target decode, medium timing
		case (c_r.ds)
			DS_IDLE: begin
				if (t_hit) begin
					c_nxt.ds = DS_WAIT;
				end
			end
			DS_WAIT: begin
				c_nxt.ds = DS_ACT;
			end
			DS_ACT: begin
				if (tgt_done_in) begin
					c_nxt.ds = DS_PARK;
				end
			end
			default: begin
				c_nxt.ds = DS_IDLE;
			end
		endcase
		// Clock run: only asks while the resource has let go
		if (c_r.ckr_cnt != 2'h0) begin
			c_nxt.ckr_cnt = c_r.ckr_cnt - 2'h1;
		end else if (clk_need_in && clkrun_n_in && bus_power_good_in) begin
			c_nxt.ckr_cnt = CLKRUN_HOLD_CLKS;
		end
		// Bus reset overrides cmd, isr, imr, master wait, DEVSEL and PERR state; not the CLKRUN count
		if (!bus_reset_n) begin
			c_nxt.cmd      = CMD_RST;
			c_nxt.isr      = ISR_RST;
			c_nxt.imr      = IMR_RST;
			c_nxt.mst_wait = 1'b0;
			c_nxt.ds       = DS_IDLE;
			c_nxt.pe       = PE_IDLE;
			c_nxt.rst_cnt  = (c_r.rst_cnt == BUS_RST_MIN_CLKS) ? c_r.rst_cnt : c_r.rst_cnt + 4'h1;
			c_nxt.rst_ok   = (c_nxt.rst_cnt == BUS_RST_MIN_CLKS);
		end else begin
			c_nxt.rst_cnt = 4'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_r <= CORE_RST;
		end else begin
			c_r <= c_nxt;
		end
	end

	// ----------------------------------------
	// Sticky power management
	// ----------------------------------------
	always_comb begin
		pm_nxt = pm_r;
		if (wr && paddr == OFS_PM) begin
			pm_nxt.pme_en  = pwdata[PM_PME_EN];
			pm_nxt.form    = wake_form_e'(pwdata[PM_FORM_LO +: 2]);
			pm_nxt.cardbus = pwdata[PM_CARDBUS];
			if (pwdata[PM_PME_ST]) begin
				pm_nxt.pme_st = 1'b0;
			end
			if (pwdata[PM_WAKE_ST]) begin
				pm_nxt.wake_st = 1'b0;
			end
		end
		if (wake_ev) begin
			pm_nxt.pme_st  = 1'b1;
			pm_nxt.wake_st = 1'b1;
			pm_nxt.pcnt    = WAKE_PULSE_CYC;
		end else if (pm_r.pcnt != '0) begin
			pm_nxt.pcnt = pm_r.pcnt - WAKE_CNT_W'(1);
		end
		case (pm_nxt.form)
			WAKE_HIGH: begin
				pm_nxt.wake_out = pm_nxt.wake_st;
			end
			WAKE_LOW: begin
				pm_nxt.wake_out = ~pm_nxt.wake_st;
			end
			WAKE_POS: begin
				pm_nxt.wake_out = pm_nxt.pcnt != '0;
			end
			default: begin
				pm_nxt.wake_out = pm_nxt.pcnt == '0;
			end
		endcase
		pm_nxt.cst = pm_nxt.cardbus & pm_nxt.pme_st & pm_nxt.pme_en;
	end

	// Survives bus reset so a wake from D3cold is not lost
	always_ff @(posedge pclk or negedge aux_sticky_reset_n) begin
		if (!aux_sticky_reset_n) begin
			pm_r <= PM_RST;
		end else begin
			pm_r <= pm_nxt;
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	od_pin u_inta (
		.clk       (pclk),
		.rst_n     (presetn),
		.en        (live),
		.assert_in (|(c_r.isr & c_r.imr)),
		.pin_n_out (inta_n_out),
		.pin_oe    (inta_oe)
	);

	od_pin u_serr (
		.clk       (pclk),
		.rst_n     (presetn),
		.en        (live),
		.assert_in (c_r.serr),
		.pin_n_out (serr_n_out),
		.pin_oe    (serr_oe)
	);

	od_pin u_pme (
		.clk       (pclk),
		.rst_n     (aux_sticky_reset_n),
		.en        (1'b1),
		.assert_in (pm_r.pme_st & pm_r.pme_en),
		.pin_n_out (pme_n_out),
		.pin_oe    (pme_oe)
	);

	od_pin u_ckr (
		.clk       (pclk),
		.rst_n     (presetn),
		.en        (bus_power_good_in),
		.assert_in (c_r.ckr_cnt != 2'h0),
		.pin_n_out (clkrun_n_out),
		.pin_oe    (clkrun_oe)
	);

	assign pready         = 1'b1;
	assign prdata         = c_r.rdata;
	assign pslverr        = c_r.slverr & psel & penable;
	assign req_n_out      = ~c_r.req;
	assign req_oe         = c_r.req & live;
	assign mst_grant_out  = c_r.req & ~gnt_n_in & live;
	assign mst_abort_out  = c_r.mst_abort;
	assign mst_stop_out   = c_r.mst_stop;
	assign cfg_access_out = c_r.cfg;
	assign devsel_n_out   = c_r.ds != DS_ACT;
	assign devsel_oe      = (c_r.ds == DS_ACT || c_r.ds == DS_PARK) & live;
	assign perr_n_out     = c_r.pe != PE_LOW;
	assign perr_oe        = (c_r.pe != PE_IDLE) & live;
	assign wake_event_out = pm_r.wake_out;
	assign cstschg_out    = pm_r.cst;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_REQ_RESET: assert property (!bus_reset_n |-> !req_oe && !mst_grant_out)
		else $error("REQ driven or grant taken in bus reset");
	AST_BUS_POWER_GOOD_IN_ISOL: assert property (!bus_power_good_in |->
		!(req_oe || devsel_oe || perr_oe || serr_oe || inta_oe || par_oe))
		else $error("Bus pin driven without power good");
	AST_DEVSEL_MED: assert property (t_hit && c_r.ds == DS_IDLE ##1 live ##1 live
		|-> devsel_oe && !devsel_n_out)
		else $error("DEVSEL not driven two clocks after address");
	AST_MST_ABORT: assert property (live && mst_cmd_in
		##1 (!dsel_seen && !mst_cmd_in && bus_reset_n)[*5] |=> mst_abort_out && !c_r.cmd[CMD_MST_EN])
		else $error("Master abort missing after five clocks");
	AST_SERR_PULSE: assert property (addr_err && c_r.cmd[CMD_SERR_EN] && live
		##1 live && !addr_err ##1 live |-> serr_oe ##1 !serr_oe)
		else $error("SERR pulse wrong");
	AST_SERR_BITS: assert property (addr_err && c_r.cmd[CMD_SERR_EN] && bus_reset_n
		|=> c_r.cmd[ST_DET_PERR] && c_r.cmd[ST_SIG_SERR])
		else $error("System error bits not set");
	AST_BUS_ERR: assert property ((addr_err || (data_err && is_master_in))
		&& c_r.cmd[CMD_PAR_RESP] && bus_reset_n |=> c_r.isr[ISR_BUS_ERR])
		else $error("Bus error status not set");
	AST_INTA: assert property (live && $stable(live) && |(c_r.isr & c_r.imr)
		|=> inta_oe == live)
		else $error("INTA not asserted for pending interrupt");
	AST_PERR_TGT: assert property (c_r.pe == PE_IDLE && data_err && !is_master_in
		&& c_r.cmd[CMD_PAR_RESP] ##1 live |-> perr_oe && !perr_n_out ##1 (!perr_oe || perr_n_out))
		else $error("Target PERR not driven");

	CVR_ABORT: cover property (mst_abort_out);
	CVR_SERR:  cover property (serr_oe);
	CVR_DSEL:  cover property (devsel_oe && !devsel_n_out);
	CVR_WAKE:  cover property (wake_ev && pm_r.pme_en);
endmodule
`default_nettype wire

// [bench/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host bridge, arbiter and clock resource
// ----------------------------------------
module host_model (
	input  wire logic       pclk,
	input  wire logic       req_n,
	input  wire logic       req_oe,
	input  wire logic       gnt_all,
	input  wire logic       tgt_cmd,
	input  wire logic [3:0] tgt_wait,
	input  wire logic       dsel_oe,
	input  wire logic       dsel_n,
	input  wire logic       crun_oe,
	input  wire logic       clk_stop,
	output logic            gnt_n,
	output logic            devsel_n,
	output logic            clkrun_n
);
	logic [3:0] cnt_r;
	logic       ans_r;
	logic       run_r;

	initial begin
		gnt_n = 1'b1;
		cnt_r = 4'h0;
		ans_r = 1'b0;
		run_r = 1'b1;
	end

	// Grant when asked, and to all under gnt_all even in reset, to prove it is ignored
	always @(posedge pclk) begin
		gnt_n <= !(gnt_all || (req_oe && !req_n));
		if (tgt_cmd) begin
			cnt_r <= tgt_wait;
			ans_r <= 1'b0;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
			ans_r <= (cnt_r == 4'h1);
		end else begin
			ans_r <= 1'b0;
		end
		if (crun_oe)
			run_r <= 1'b1;
		else if (clk_stop)
			run_r <= 1'b0;
	end

	// Released lines read high unless the host drives them (DEVSEL answer, clock running)
	assign devsel_n = dsel_oe ? dsel_n : !ans_r;
	assign clkrun_n = !(crun_oe || run_r);
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sideband_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, ad_in, v;
	logic [3:0]  cbe_in, tgt_wait;
	logic [15:0] irq_evt_in;
	logic        aux_sticky_reset_n, bus_reset_n, bus_power_good_in, idsel_in, addr_phase_in, data_phase_in;
	logic        par_in, par_drive_in, par_out, par_oe, is_master_in, mst_req_in, gnt_n_in, req_n_out, req_oe;
	logic        mst_grant_out, mst_cmd_in, devsel_n_in, mst_abort_out, mst_stop_out, tgt_hit_in, tgt_done_in;
	logic        cfg_access_out, devsel_n_out, devsel_oe, perr_n_out, perr_oe, serr_n_out, serr_oe;
	logic        inta_n_out, inta_oe, pme_n_out, pme_oe, clkrun_n_in, clk_need_in, clkrun_n_out, clkrun_oe;
	logic        wake_pkt_in, link_chg_in, wake_frame_in, wake_event_out, cstschg_out, gnt_all, clk_stop, e;
	int          i, k, cnt, cf, ds, cycles, bad_count, n_checks;

	pci_sideband dut (.*);

	host_model partner (.pclk(pclk), .req_n(req_n_out), .req_oe(req_oe), .gnt_all(gnt_all),
		.tgt_cmd(mst_cmd_in), .tgt_wait(tgt_wait), .dsel_oe(devsel_oe), .dsel_n(devsel_n_out),
		.crun_oe(clkrun_oe), .clk_stop(clk_stop), .gnt_n(gnt_n_in), .devsel_n(devsel_n_in),
		.clkrun_n(clkrun_n_in));

	// ----------------------------------------
	// Clock, timeout, verdict
	// ----------------------------------------
	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			print_verdict;
		end
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// ----------------------------------------
	// APB master, waits for pready
	// ----------------------------------------
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        er;
		apb(a, 1'b1, d, r, er);
	endtask

	task rd(input logic [7:0] a);
		apb(a, 1'b0, 32'h0000_0000, v, e);
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, idsel_in, addr_phase_in, data_phase_in, ad_in, cbe_in} = '0;
		{par_in, par_drive_in, is_master_in, mst_req_in, mst_cmd_in, tgt_hit_in, tgt_done_in} = '0;
		{clk_need_in, irq_evt_in, wake_pkt_in, link_chg_in, wake_frame_in, tgt_wait, gnt_all, clk_stop} = '0;
		{presetn, aux_sticky_reset_n} = 2'b00;
		{bus_reset_n, bus_power_good_in} = 2'b11;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		aux_sticky_reset_n <= 1'b1;

		rd(OFS_CMD);
		chk(v, CMD_RST, "cmd reset");
		apb(8'h40, 1'b0, 32'h0000_0000, v, e);
		chk({v[30:0], e}, 32'h1, "unmapped");
		wr(OFS_CMD, CMD_RW_MASK);
		$display("test registers done");

		// Config access with bad address parity
		@(posedge pclk);
		addr_phase_in <= 1'b1;
		idsel_in <= 1'b1;
		ad_in <= 32'h0000_0001;
		cbe_in <= 4'h0;
		@(posedge pclk);
		addr_phase_in <= 1'b0;
		idsel_in <= 1'b0;
		par_in <= ~(^{ad_in, cbe_in});
		{cnt, cf, ds} = '0;
		for (i = 0; i < 8; i++) begin
			#1;
			cnt += (serr_oe === 1'b1 && serr_n_out === 1'b0);
			cf += (cfg_access_out === 1'b1);
			if (ds == 0 && devsel_oe === 1'b1 && devsel_n_out === 1'b0)
				ds = i;
			@(posedge pclk);
		end
		par_in <= 1'b0;
		chk(cnt, 1, "serr width");
		chk(cf, 1, "cfg select");
		chk(ds inside {[1:2]}, 1'b1, "devsel time");
		tgt_done_in <= 1'b1;
		@(posedge pclk);
		tgt_done_in <= 1'b0;
		tick(3);
		chk(devsel_oe, 1'b0, "devsel release");
		rd(OFS_CMD);
		chk(v, CMD_RW_MASK | 32'hc000_0000, "cmd serr");
		rd(OFS_ISR);
		chk(v, 32'h0000_2000, "isr bus err");
		$display("test address parity done");

		wr(OFS_IMR, 32'h0000_2000);
		tick(2);
		chk({inta_oe, inta_n_out}, 2'b10, "inta on");
		wr(OFS_ISR, 32'h0000_2000);
		tick(2);
		chk(inta_oe, 1'b0, "inta off");
		wr(OFS_CMD, CMD_RW_MASK | 32'hc000_0000);
		$display("test interrupt done");

		// Prompt target, then no target at all
		for (i = 0; i < 2; i++) begin
			@(posedge pclk);
			tgt_wait <= i ? 4'h0 : 4'h2;
			mst_cmd_in <= 1'b1;
			@(posedge pclk);
			mst_cmd_in <= 1'b0;
			cnt = 0;
			for (k = 0; k < 10; k++) begin
				tick(1);
				cnt += (mst_abort_out === 1'b1);
			end
			chk(cnt, i, "abort count");
		end
		rd(OFS_CMD);
		chk(v, 32'h2000_0140, "cmd abort");
		$display("test master abort done");

		// Abort dropped master enable; give it back
		wr(OFS_CMD, CMD_RW_MASK);
		wr(OFS_PM, 32'h0004_0100);
		@(posedge pclk);
		wake_pkt_in <= 1'b1;
		mst_req_in <= 1'b1;
		@(posedge pclk);
		wake_pkt_in <= 1'b0;
		tick(4);
		chk({pme_oe, pme_n_out, cstschg_out, wake_event_out}, 4'b1011, "pme");
		chk({req_oe, req_n_out, mst_grant_out}, 3'b101, "request");
		// Chip reset inside bus reset: sticky bits must survive both
		@(posedge pclk);
		bus_reset_n <= 1'b0;
		presetn <= 1'b0;
		gnt_all <= 1'b1;
		@(posedge pclk);
		presetn <= 1'b1;
		tick(11);
		chk({req_oe, mst_grant_out, devsel_oe, serr_oe, inta_oe}, 5'h0, "bus reset");
		@(posedge pclk);
		bus_reset_n <= 1'b1;
		gnt_all <= 1'b0;
		mst_req_in <= 1'b0;
		rd(OFS_CMD);
		chk(v, 32'h0000_0000, "cmd cleared");
		rd(OFS_PM);
		chk(v & 32'h0000_8100, 32'h0000_8100, "pme sticky");
		rd(OFS_SIDE);
		chk({v[5], v[1], v[0]}, 3'b111, "side");
		$display("test reset and pme done");

		// Every wake form, cleared between
		for (i = 0; i < 4; i++) begin
			wr(OFS_PM, 32'h0008_8000 | (32'(i) << 16));
			tick(2);
			chk(wake_event_out, i[0], "wake idle");
			@(posedge pclk);
			if (i[1])
				link_chg_in <= 1'b1;
			else
				wake_frame_in <= 1'b1;
			@(posedge pclk);
			link_chg_in <= 1'b0;
			wake_frame_in <= 1'b0;
			tick(3);
			chk(wake_event_out, !i[0], "wake active");
			tick(12);
			chk(wake_event_out, i[1] ? i[0] : !i[0], "wake after");
		end
		$display("test wake forms done");

		@(posedge pclk);
		bus_power_good_in <= 1'b0;
		addr_phase_in <= 1'b1;
		tgt_hit_in <= 1'b1;
		@(posedge pclk);
		addr_phase_in <= 1'b0;
		tgt_hit_in <= 1'b0;
		tick(4);
		chk({devsel_oe, req_oe, par_oe, serr_oe}, 4'h0, "isolated");
		@(posedge pclk);
		bus_power_good_in <= 1'b1;
		par_drive_in <= 1'b1;
		ad_in <= 32'h0000_0003;
		cbe_in <= 4'h1;
		@(posedge pclk);
		par_drive_in <= 1'b0;
		#1;
		chk({par_oe, par_out}, {1'b1, ^{ad_in, cbe_in}}, "parity out");
		$display("test isolation and parity done");

		// Bad data parity as target, then as master
		wr(OFS_CMD, CMD_RW_MASK);
		for (i = 0; i < 2; i++) begin
			@(posedge pclk);
			is_master_in <= i[0];
			data_phase_in <= 1'b1;
			@(posedge pclk);
			data_phase_in <= 1'b0;
			par_in <= ~(^{ad_in, cbe_in});
			@(posedge pclk);
			#1;
			chk({perr_oe, perr_n_out, mst_stop_out}, i ? 3'b011 : 3'b100, "data parity");
		end
		rd(OFS_CMD);
		chk(v, CMD_RW_MASK | 32'h0100_0000, "cmd data parity");
		$display("test data parity done");

		@(posedge pclk);
		clk_stop <= 1'b1;
		@(posedge pclk);
		clk_stop <= 1'b0;
		tick(1);
		chk(clkrun_n_in, 1'b1, "clock stopped");
		@(posedge pclk);
		clk_need_in <= 1'b1;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (clkrun_oe !== 1'b1 && k < 6);
		chk({clkrun_oe, clkrun_n_out}, 2'b10, "clock request");
		@(posedge pclk);
		clk_need_in <= 1'b0;
		tick(4);
		chk({clkrun_oe, clkrun_n_in}, 2'b00, "clock kept");
		$display("test clock run done");
		print_verdict;
	end
endmodule
`default_nettype wire
